// ---- logic/dets_timestamper.sv ----
// Top of the two-input edge timestamper: capture, image and lamps.
// Assumes inputs arrive asynchronously; configuration and status
// inputs come from logic on sys_clk.
`timescale 1ns/100ps
module dets_timestamper #(
  parameter int unsigned BLINK_HALF_US = dets_pkg::BLINK_HALF_US
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        first_input,
  input  wire logic        second_input,
  input  wire logic        cfg_large_image,
  input  wire logic [1:0]  cfg_rise_en,
  input  wire logic [1:0]  cfg_fall_en,
  input  wire logic        bus_comm_ok,
  input  wire logic        bus_supply_ok,
  input  wire logic        module_error,
  input  wire logic        config_error,
  input  wire logic [5:0]  img_rd_addr,
  output logic      [7:0]  img_rd_data,
  output logic             run_led,
  output logic             module_fault_indicator,
  output logic      [1:0]  channel_indicator
);
  localparam int unsigned NE = dets_pkg::ENTRIES_LARGE;
  localparam logic [3:0] LAST_SMALL = 4'(dets_pkg::ENTRIES_SMALL - 1);
  localparam logic [3:0] LAST_LARGE = 4'(dets_pkg::ENTRIES_LARGE - 1);

  // Entry counts must fit the four-bit index and nest small within large
  if ((dets_pkg::ENTRIES_LARGE > 16) || (dets_pkg::ENTRIES_SMALL > NE)) begin : g_chk
    $error("entry counts do not fit the four-bit index");
  end

  dets_time_if tm ();

  logic [1:0]  in_meta_ff;
  logic [1:0]  in_sync_ff;
  logic [1:0]  in_prev_ff;
  logic [2:0]  settle_ff;
  logic [6:0]  seq_ff;
  logic [3:0]  wr_idx_ff;
  logic [31:0] image_mem [NE];
  logic [1:0]  rise_hit;
  logic [1:0]  fall_hit;
  logic        capture;
  logic [3:0]  last_idx;
  logic [3:0]  rd_entry;

  // Microsecond time base
  dets_us_timer u_timer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .tm      (tm.src)
  );

  // Run and fault lamps
  dets_led_drive #(
    .BLINK_HALF_US (BLINK_HALF_US)
  ) u_led (
    .sys_clk                (sys_clk),
    .rst_b                  (rst_b),
    .tm                     (tm.snk),
    .bus_comm_ok            (bus_comm_ok),
    .bus_supply_ok          (bus_supply_ok),
    .module_error           (module_error),
    .config_error           (config_error),
    .run_led                (run_led),
    .module_fault_indicator (module_fault_indicator)
  );

  // Pick the byte of an entry word at a lane, little-endian stamp
  function automatic logic [7:0] entry_byte(input logic [31:0] w,
                                            input logic [1:0]  lane);
    logic [7:0] b;
    b = 8'h00;
    unique case (lane)
      dets_pkg::OFF_STATE:    b = w[7:0];
      dets_pkg::OFF_SEQ:      b = w[15:8];
      dets_pkg::OFF_STAMP_LO: b = w[23:16];
      dets_pkg::OFF_STAMP_HI: b = w[31:24];
    endcase
    return b;
  endfunction

  // Two-stage synchroniser on the input pins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_meta_ff <= 2'h0;
      in_sync_ff <= 2'h0;
    end else begin
      in_meta_ff <= {second_input, first_input};
      in_sync_ff <= in_meta_ff;
    end
  end

  // Previous level and settle time so reset does not fake an edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_prev_ff <= 2'h0;
      settle_ff  <= 3'h0;
    end else begin
      in_prev_ff <= in_sync_ff;
      settle_ff  <= {settle_ff[1:0], 1'b1};
    end
  end

  // Edge detection against the configured edge selection
  assign rise_hit = in_sync_ff & ~in_prev_ff & cfg_rise_en;
  assign fall_hit = ~in_sync_ff & in_prev_ff & cfg_fall_en;
  assign capture  = settle_ff[2] && (|(rise_hit | fall_hit));
  assign last_idx = cfg_large_image ? LAST_LARGE : LAST_SMALL;

  // Sequence number in capture order, starting at one
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_ff <= dets_pkg::SEQ_RESET;
    end else if (capture) begin
      seq_ff <= seq_ff + 7'h01;
    end
  end

  // Ring write position; a shrunk image also wraps at once
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_idx_ff <= 4'h0;
    end else if (capture) begin
      wr_idx_ff <= (wr_idx_ff >= last_idx) ? 4'h0 : wr_idx_ff + 4'h1;
    end
  end

  // Entry store: state byte, sequence byte, low stamp word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NE; i++) begin
        image_mem[i] <= 32'h0000_0000;
      end
    end else if (capture) begin
      image_mem[wr_idx_ff] <= {tm.us_count[15:0],
                               1'b0, seq_ff,
                               6'h00, in_sync_ff};
    end
  end

  // Byte read of the input image; entry n at byte 4n
  assign rd_entry = img_rd_addr[5:2];
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      img_rd_data <= 8'h00;
    end else if (rd_entry <= last_idx) begin
      img_rd_data <= entry_byte(image_mem[rd_entry], img_rd_addr[1:0]);
    end else begin
      img_rd_data <= 8'h00;
    end
  end

  // Channel lamps follow inputs regardless of module state.
  // No output image exists, so there is no write path at all.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_indicator <= 2'h0;
    end else begin
      channel_indicator <= in_sync_ff;
    end
  end

  sequence s_first_rise;
    settle_ff[2] && !in_prev_ff[0] ##0 in_sync_ff[0] && cfg_rise_en[0];
  endsequence

  sequence s_stamp_kept;
    ##1 image_mem[$past(wr_idx_ff)][31:16] == $past(tm.us_count[15:0]);
  endsequence

  a_edge_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_first_rise |-> capture)
    else $error("enabled edge not captured");
  a_seq_advance: assert property (@(posedge sys_clk) disable iff (!rst_b)
    capture |=> seq_ff == $past(seq_ff) + 7'h01)
    else $error("sequence did not advance");
  a_seq_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !capture |=> $stable(seq_ff))
    else $error("sequence moved without edge");
  a_ring_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (capture && wr_idx_ff == last_idx) |=> wr_idx_ff == 4'h0)
    else $error("write position did not wrap");
  a_stamp_kept: assert property (@(posedge sys_clk) disable iff (!rst_b)
    capture |-> s_stamp_kept)
    else $error("stamp not stored");
  a_state_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
    capture |=> image_mem[$past(wr_idx_ff)][7:0] == {6'h00, $past(in_sync_ff)})
    else $error("state byte wrong");
  a_read_pad: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!cfg_large_image && img_rd_addr >= 6'h14) |=> img_rd_data == 8'h00)
    else $error("unused image byte not zero");
  a_lamp_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
    in_sync_ff[1] |=> channel_indicator[1])
    else $error("channel lamp not lit");

  // Capture steps for the other channel and direction
  sequence s_first_fall;
    settle_ff[2] && in_prev_ff[0] && !in_sync_ff[0] && cfg_fall_en[0];
  endsequence

  sequence s_second_rise;
    settle_ff[2] && !in_prev_ff[1] && in_sync_ff[1] && cfg_rise_en[1];
  endsequence

  sequence s_second_fall_off;
    in_prev_ff[1] && !in_sync_ff[1] && !cfg_fall_en[1] && (in_sync_ff[0] == in_prev_ff[0]);
  endsequence

  a_fall_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_first_fall |-> capture)
    else $error("enabled falling edge not captured");
  a_second_rise: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_second_rise |-> capture)
    else $error("second input rise not captured");
  a_fall_masked: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_second_fall_off |-> !capture)
    else $error("disabled edge captured");
  a_arm_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !settle_ff[2] |-> !capture)
    else $error("capture before arming");
  a_still_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (in_sync_ff == in_prev_ff) |-> !capture)
    else $error("capture without any edge");

  // Sequence and write position bookkeeping
  a_seq_byte: assert property (@(posedge sys_clk) disable iff (!rst_b)
    capture |=> image_mem[$past(wr_idx_ff)][15:8] == {1'b0, $past(seq_ff)})
    else $error("sequence byte wrong");
  a_seq_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (capture && seq_ff == 7'h7F) |=> seq_ff == 7'h00)
    else $error("sequence did not wrap");
  a_idx_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (capture && wr_idx_ff < last_idx) |=> wr_idx_ff == $past(wr_idx_ff) + 4'h1)
    else $error("write position did not step");
  a_idx_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !capture |=> $stable(wr_idx_ff))
    else $error("write position moved without edge");
  a_idx_small: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (capture && !cfg_large_image) |=> wr_idx_ff <= LAST_SMALL)
    else $error("write position past small image");
  a_idx_wrap_small: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (capture && !cfg_large_image && wr_idx_ff == LAST_SMALL) |=> wr_idx_ff == 4'h0)
    else $error("small ring did not wrap");

  // Live image reads, one step per byte lane
  sequence s_read_state;
    (rd_entry <= last_idx) && (img_rd_addr[1:0] == dets_pkg::OFF_STATE);
  endsequence

  sequence s_read_seq;
    (rd_entry <= last_idx) && (img_rd_addr[1:0] == dets_pkg::OFF_SEQ);
  endsequence

  sequence s_read_lo;
    (rd_entry <= last_idx) && (img_rd_addr[1:0] == dets_pkg::OFF_STAMP_LO);
  endsequence

  sequence s_read_hi;
    (rd_entry <= last_idx) && (img_rd_addr[1:0] == dets_pkg::OFF_STAMP_HI);
  endsequence

  a_state_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_read_state |=> img_rd_data == $past(image_mem[rd_entry][7:0]))
    else $error("state byte read wrong");
  a_state_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_read_state |=> img_rd_data[7:2] == 6'h00)
    else $error("state byte upper bits set");
  a_seq_top: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_read_seq |=> !img_rd_data[7])
    else $error("sequence byte top bit set");
  a_stamp_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_read_lo |=> img_rd_data == $past(image_mem[rd_entry][23:16]))
    else $error("stamp low byte read wrong");
  a_stamp_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_read_hi |=> img_rd_data == $past(image_mem[rd_entry][31:24]))
    else $error("stamp high byte read wrong");
  a_pad_large: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg_large_image && rd_entry == 4'hF) |=> img_rd_data == 8'h00)
    else $error("byte past large image not zero");

  // Lamps
  a_lamp_first: assert property (@(posedge sys_clk) disable iff (!rst_b)
    in_sync_ff[0] |=> channel_indicator[0])
    else $error("first channel lamp not lit");
  a_lamp_dark: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (in_sync_ff == 2'h0) |=> (channel_indicator == 2'h0))
    else $error("channel lamp lit at zero");
  a_lamp_dark_second: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !in_sync_ff[1] |=> !channel_indicator[1])
    else $error("second channel lamp lit at zero");
  a_lamp_unpowered: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!bus_supply_ok && in_sync_ff[0]) |=> channel_indicator[0])
    else $error("channel lamp dark without supply");
  a_run_lit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (bus_supply_ok && bus_comm_ok) |=> run_led)
    else $error("run lamp dark with bus up");
  a_run_dark_supply: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !bus_supply_ok |=> !run_led)
    else $error("run lamp lit without supply");
  a_fault_dark: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !bus_supply_ok |=> !module_fault_indicator)
    else $error("fault lamp lit without supply");
  a_fault_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (bus_supply_ok && !config_error && !module_error) |=> !module_fault_indicator)
    else $error("fault lamp lit without fault");
endmodule // dets_timestamper

// ---- common/dets_pkg.sv ----
// Constants for the dual-input edge timestamper.
// Assumes one 20 MHz clock and an active-low asynchronous reset.
// Operation
// - Configured edge captures time, state, sequence
// - Image holds five or fifteen entries
// - Entry: state, sequence, sixteen-bit stamp
// - Entry n starts at byte four times n
// - State bits 0,1 inputs; rest zero
// - Sequence starts at one, wraps 0..127
// - Free-running 32-bit microsecond counter from zero
// - Counter rolls over to zero
// - Stamp keeps low sixteen counter bits
// - No output image bytes used
// - Channel lamp follows its input level
// - Fault lamp steady on error, blinks config
// - Run lamp off without bus communication
// - Channel lamps work without electronics supply
package dets_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned US_PERIOD_NS  = 1000;
  localparam int unsigned CYC_PER_US    = US_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W       = 32;
  localparam int unsigned ENTRY_BYTES   = 4;
  localparam int unsigned ENTRIES_SMALL = 5;
  localparam int unsigned ENTRIES_LARGE = 15;
  localparam int unsigned IMG_AW        = 6;
  localparam int unsigned IDX_W         = 4;
  localparam logic [1:0]  OFF_STATE     = 2'h0;
  localparam logic [1:0]  OFF_SEQ       = 2'h1;
  localparam logic [1:0]  OFF_STAMP_LO  = 2'h2;
  localparam logic [1:0]  OFF_STAMP_HI  = 2'h3;
  localparam logic [6:0]  SEQ_RESET     = 7'h01;
  localparam logic [31:0] TIMER_RESET   = 32'h0000_0000;
  localparam logic [31:0] TIMER_MAX     = 32'hFFFF_FFFF;
  localparam int unsigned BLINK_HZ      = 2;
  localparam int unsigned BLINK_HALF_US = 1000000 / (2 * BLINK_HZ);
endpackage

// ---- common/dets_time_if.sv ----
// Microsecond time base carried from the timer to its users.
// Assumes all parties run on the same sys_clk.
`timescale 1ns/100ps
interface dets_time_if;
  logic        us_tick;
  logic [31:0] us_count;
  modport src (output us_tick, output us_count);
  modport snk (input us_tick, input us_count);
endinterface // dets_time_if

// ---- logic/dets_us_timer.sv ----
// Microsecond prescaler and 32-bit free-running counter.
// Assumes sys_clk at the rate named in the package.
`timescale 1ns/100ps
module dets_us_timer (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  dets_time_if.src  tm
);
  localparam int unsigned PW = $clog2(dets_pkg::CYC_PER_US);
  localparam logic [PW-1:0] PRE_LAST = PW'(dets_pkg::CYC_PER_US - 1);
  logic [PW-1:0] pre_ff;

  // Prescaler gives one tick per microsecond
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_ff     <= '0;
      tm.us_tick <= 1'b0;
    end else begin
      tm.us_tick <= (pre_ff == PRE_LAST);
      pre_ff     <= (pre_ff == PRE_LAST) ? '0 : pre_ff + 1'b1;
    end
  end

  // Counter starts from zero and wraps naturally
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tm.us_count <= dets_pkg::TIMER_RESET;
    end else if (tm.us_tick) begin
      tm.us_count <= tm.us_count + 32'h0000_0001;
    end
  end

  a_tick_period: assert property (@(posedge sys_clk) disable iff (!rst_b)
    tm.us_tick |-> ##20 tm.us_tick)
    else $error("tick period wrong");
  a_tick_gap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    tm.us_tick |=> (!tm.us_tick) [*8])
    else $error("ticks too close");
  a_count_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (tm.us_tick && tm.us_count == dets_pkg::TIMER_MAX) |=> tm.us_count == 32'h0)
    else $error("counter did not wrap");
endmodule // dets_us_timer

// ---- logic/dets_led_drive.sv ----
// Run and fault lamp drive with 2 Hz blink.
// Assumes status inputs are on sys_clk.
`timescale 1ns/100ps
module dets_led_drive #(
  parameter int unsigned BLINK_HALF_US = dets_pkg::BLINK_HALF_US
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  dets_time_if.snk  tm,
  input  wire logic bus_comm_ok,
  input  wire logic bus_supply_ok,
  input  wire logic module_error,
  input  wire logic config_error,
  output logic      run_led,
  output logic      module_fault_indicator
);
  localparam int unsigned BW = $clog2(BLINK_HALF_US + 1);
  localparam logic [BW-1:0] B_LAST = BW'(BLINK_HALF_US - 1);
  logic [BW-1:0] blink_cnt_ff;
  logic          phase_ff;

  if (BLINK_HALF_US < 1) begin : g_chk
    $error("BLINK_HALF_US must be at least one");
  end

  // Half-period timer in microsecond ticks
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt_ff <= '0;
      phase_ff     <= 1'b0;
    end else if (tm.us_tick) begin
      blink_cnt_ff <= (blink_cnt_ff == B_LAST) ? '0 : blink_cnt_ff + 1'b1;
      if (blink_cnt_ff == B_LAST) begin
        phase_ff <= ~phase_ff;
      end
    end
  end

  // Lamp priority: supply loss, config blink, error steady
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_led                <= 1'b0;
      module_fault_indicator <= 1'b0;
    end else begin
      run_led <= bus_supply_ok && bus_comm_ok;
      if (!bus_supply_ok) begin
        module_fault_indicator <= 1'b0;
      end else if (config_error) begin
        module_fault_indicator <= phase_ff;
      end else begin
        module_fault_indicator <= module_error;
      end
    end
  end

  a_run_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !bus_comm_ok |=> !run_led)
    else $error("run lamp lit without bus");
  a_fault_steady: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (bus_supply_ok && !config_error && module_error) |=> module_fault_indicator)
    else $error("fault lamp not steady");
endmodule // dets_led_drive

// ---- verif/dets_bus_reader.sv ----
// Backplane reader model: fetches image bytes by entry and field.
// Assumes the image answers one sys_clk edge after the address.
`timescale 1ns/100ps
module dets_bus_reader (
  input  wire logic       sys_clk,
  input  wire logic       rd_req,
  input  wire logic [3:0] rd_entry,
  input  wire logic [1:0] rd_field,
  output logic      [5:0] img_rd_addr,
  output logic            rd_valid
);
  // Entry s sits at byte four times s, field picks the byte
  assign img_rd_addr = {rd_entry, rd_field};
  // Data is due one edge after the address
  always_ff @(posedge sys_clk) begin
    rd_valid <= rd_req;
  end
endmodule // dets_bus_reader

// ---- verif/dual_input_edge_timestamper_tb_top.sv ----
// Self-checking bench: random edges, image reads, lamp states.
// Assumes the reader model and the timestamper top are compiled.
`timescale 1ns/100ps
module dual_input_edge_timestamper_tb_top;
  logic        sys_clk, rst_b, first_input, second_input, cfg_large_image;
  logic [1:0]  cfg_rise_en, cfg_fall_en, rd_field, channel_indicator;
  logic        bus_comm_ok, bus_supply_ok, module_error, config_error;
  logic        rd_req, rd_valid, run_led, module_fault_indicator, s;
  logic [3:0]  rd_entry;
  logic [5:0]  img_rd_addr;
  logic [7:0]  img_rd_data, st [15];
  logic [6:0]  sq [15];
  logic [15:0] ts [15];
  logic [7:0]  exq [$];
  int          miscompares, n_checks, seed, cyc, widx, nent, seq;

  dets_timestamper #(.BLINK_HALF_US(4)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .first_input(first_input), .second_input(second_input),
    .cfg_large_image(cfg_large_image), .cfg_rise_en(cfg_rise_en),
    .cfg_fall_en(cfg_fall_en), .bus_comm_ok(bus_comm_ok),
    .bus_supply_ok(bus_supply_ok), .module_error(module_error),
    .config_error(config_error), .img_rd_addr(img_rd_addr),
    .img_rd_data(img_rd_data), .run_led(run_led),
    .module_fault_indicator(module_fault_indicator),
    .channel_indicator(channel_indicator));
  dets_bus_reader rdr (.sys_clk(sys_clk), .rd_req(rd_req), .rd_entry(rd_entry),
    .rd_field(rd_field), .img_rd_addr(img_rd_addr), .rd_valid(rd_valid));

  // Clock and cycles since reset release
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk or negedge rst_b) cyc <= rst_b ? cyc + 1 : 0;

  // Compare one byte exactly; unknown bits count as a mismatch
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Monitor takes the oldest note for each returned byte
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      chk("img_rd_data", img_rd_data, exq[0]);
      void'(exq.pop_front());
    end
  end

  task automatic rd(input int e, f, input logic [7:0] x);
    @(negedge sys_clk);
    rd_req = 1'b1;
    rd_entry = 4'(e);
    rd_field = 2'(f);
    exq.push_back(x);
  endtask

  // Read a whole entry: state, sequence, stamp low, stamp high
  task automatic rd_ent(input int i);
    rd(i, 0, st[i]);
    rd(i, 1, {1'b0, sq[i]});
    rd(i, 2, ts[i][7:0]);
    rd(i, 3, ts[i][15:8]);
  endtask

  // Toggle one pin and record the entry if that edge is enabled
  task automatic tog(input int ch);
    @(negedge sys_clk);
    if (ch == 1) second_input = ~second_input;
    else first_input = ~first_input;
    if ((ch == 1 ? second_input : first_input) ? cfg_rise_en[ch] : cfg_fall_en[ch]) begin
      st[widx] = {6'h00, second_input, first_input};
      sq[widx] = 7'(seq);
      ts[widx] = 16'((cyc + 1) / dets_pkg::CYC_PER_US);
      seq = (seq + 1) % 128;
      widx = (widx + 1) % nent;
    end
    repeat (3 + ($random(seed) & 7)) @(negedge sys_clk);
    chk("channel_indicator", 8'(channel_indicator), {6'h00, second_input, first_input});
  endtask

  task automatic do_reset(input logic big);
    rst_b = 1'b0;
    cfg_large_image = big;
    nent = big ? 15 : 5;
    widx = 0;
    seq = 1;
    for (int i = 0; i < 15; i++) {st[i], sq[i], ts[i]} = '0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (10) @(negedge sys_clk);
  endtask

  task automatic lamp(input logic r, f);
    repeat (3) @(negedge sys_clk);
    chk("run_led", 8'(run_led), 8'(r));
    chk("module_fault_indicator", 8'(module_fault_indicator), 8'(f));
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well past the expected run length
  initial begin
    #(50 * 30000);
    miscompares++;
    wrap_up();
  end

  initial begin
    seed = 32;
    {first_input, second_input, rd_req, rd_entry, rd_field} = '0;
    {bus_comm_ok, bus_supply_ok, module_error, config_error} = 4'h C;
    cfg_rise_en = 2'h3;
    cfg_fall_en = 2'h1;
    for (int v = 0; v < 2; v++) begin
      do_reset(v[0]);
      rd(nent, 0, 8'h00);
      @(negedge sys_clk);
      rd_req = 1'b0;
      repeat (v * 170 + 14) tog($random(seed) & 1);
      for (int i = 0; i < nent; i++) rd_ent(i);
      rd(nent, 1, 8'h00);
      @(negedge sys_clk);
      rd_req = 1'b0;
      repeat (3) @(negedge sys_clk);
      $display("test image variant %0d done", v);
    end
    module_error = 1'b1;
    lamp(1'b1, 1'b1);
    module_error = 1'b0;
    config_error = 1'b1;
    repeat (3) @(negedge sys_clk);
    s = module_fault_indicator;
    repeat (80) @(negedge sys_clk);
    chk("module_fault_indicator", 8'(module_fault_indicator), {7'h00, ~s});
    config_error = 1'b0;
    bus_comm_ok = 1'b0;
    lamp(1'b0, 1'b0);
    bus_supply_ok = 1'b0;
    bus_comm_ok = 1'b1;
    module_error = 1'b1;
    lamp(1'b0, 1'b0);
    tog(0);
    $display("test lamps done");
    wrap_up();
  end
endmodule // dual_input_edge_timestamper_tb_top
